// [core/cdt_debug_csrs.sv]
`timescale 1ns/1ns
// Notes on behaviour
// - version field reads fixed external-debug value
// - machine ebreak enters debug when enabled
// - user ebreak enters debug when enabled
// - counter and timer stop read zero
// - cause recorded by highest priority
// - step runs one instruction then halts
// - stepped exception halts before handler runs
// - privilege saved on entry, restored on exit
// - resume PC saved on entry, used on exit
// - select maps data CSRs onto unit
// - oversized select clips to last unit
// - data one top bits read match type
// - action bit writable only from debug
// - hit flag sticky until cleared
// - units compare addresses only
// - trailing ones encode aligned region size
// - shared enable gates exception triggers
// - debug trigger halts, cause two, hit
// - exception trigger: cause three, enable push
// - debug action wins over exception
// - trigger halt reported to debug module
// - trap return restores enable from previous
module cdt_debug_csrs
  import cdt_pkg::*;
#(
  parameter int NUM_TRIG = 2
)(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // CSR access
  input wire cdt_csr_req_s i_csr,
  output logic [31:0] o_csr_rdata,
  // Core state and events
  input wire cdt_pipe_s i_pipe,
  input wire logic [1:0] i_priv,
  input wire logic i_debug_mode,
  input wire logic i_ebreak,
  input wire logic i_halt_req,
  input wire logic i_retire,
  input wire logic i_exception,
  input wire logic i_mtrap,
  input wire logic i_mret,
  input wire logic i_dret,
  // Debug and trap requests
  output logic o_enter_debug,
  output logic o_halted,
  output logic o_trig_exc,
  output logic [31:0] o_trig_epc,
  output logic [3:0] o_trig_cause,
  output logic o_ebreak_exc,
  output logic [31:0] o_resume_pc,
  output logic [1:0] o_resume_priv
);
  localparam int IW = (NUM_TRIG > 1) ? $clog2(NUM_TRIG) : 1;
  localparam logic [IW-1:0] LAST_IDX = IW'(NUM_TRIG - 1);

  // Unit index field only reaches eight units
  if (NUM_TRIG < 1 || NUM_TRIG > 8) begin : g_bad_count
    $error("NUM_TRIG must be 1 to 8");
  end

  logic ebm_reg, ebu_reg, step_reg;
  logic [2:0] cause_reg;
  logic [1:0] prv_reg;
  logic [31:0] rpc_reg, ds0_reg, ds1_reg;
  logic [IW-1:0] tsel_reg;
  logic mte_reg, mpte_reg;
  logic [NUM_TRIG-1:0] dmode_reg, act_reg, hit_reg, mm_reg, mu_reg;
  logic [NUM_TRIG-1:0] ex_reg, st_reg, ld_reg;
  logic [3:0] match_reg [NUM_TRIG];
  logic [31:0] taddr_reg [NUM_TRIG];
  logic stepping_reg;
  logic enter_reg, halted_reg, texc_reg, ebexc_reg;
  logic [31:0] tepc_reg, rdata_reg;

  logic [NUM_TRIG-1:0] fire, fire_dbg, fire_exc;
  logic [31:0] td1_sel;
  logic [31:0] td1_word [NUM_TRIG];
  logic [31:0] dcs_val;
  logic [31:0] rdata_next;
  logic w_dcs, w_rpc, w_ds0, w_ds1, w_tsel, w_td1, w_td2, w_tctl;
  logic td_wr_ok;
  logic any_dbg, any_exc, ebreak_dbg, step_done, enter_now;
  logic [2:0] cause_next;
  logic priv_m;

  function automatic logic [31:0] td1_pack(input int i);
    logic [31:0] v;
    v = 32'h0;
    v[CDT_TYPE_LSB +: 4] = CDT_TRIG_TYPE;
    v[CDT_DMODE_BIT] = dmode_reg[i];
    v[CDT_HIT_BIT] = hit_reg[i];
    v[CDT_ACTION_LSB] = act_reg[i];
    v[CDT_MATCH_LSB +: 4] = match_reg[i];
    v[CDT_M_BIT] = mm_reg[i];
    v[CDT_U_BIT] = mu_reg[i];
    v[CDT_EXEC_BIT] = ex_reg[i];
    v[CDT_STORE_BIT] = st_reg[i];
    v[CDT_LOAD_BIT] = ld_reg[i];
    return v;
  endfunction : td1_pack

  assign priv_m = (i_priv == CDT_PRV_M);

  // Packed in a process so a change to any field re-evaluates the word
  always_comb begin
    for (int i = 0; i < NUM_TRIG; i++) begin
      td1_word[i] = td1_pack(i);
    end
  end

  generate
    for (genvar g = 0; g < NUM_TRIG; g++) begin : g_unit
      cdt_trig_unit u_unit (
        .i_ctrl(td1_word[g]),
        .i_addr(taddr_reg[g]),
        .i_priv_m(priv_m),
        .i_pipe(i_pipe),
        .o_match(fire[g])
      );
      assign fire_dbg[g] = fire[g] && act_reg[g] && !i_debug_mode;
      assign fire_exc[g] = fire[g] && !act_reg[g] && mte_reg && !i_debug_mode;
    end
  endgenerate

  // Address decode
  assign w_dcs = i_csr.we && (i_csr.addr == CDT_ADDR_DCS);
  assign w_rpc = i_csr.we && (i_csr.addr == CDT_ADDR_RPC);
  assign w_ds0 = i_csr.we && (i_csr.addr == CDT_ADDR_DS0);
  assign w_ds1 = i_csr.we && (i_csr.addr == CDT_ADDR_DS1);
  assign w_tsel = i_csr.we && (i_csr.addr == CDT_ADDR_TSEL);
  assign w_td1 = i_csr.we && (i_csr.addr == CDT_ADDR_TD1);
  assign w_td2 = i_csr.we && (i_csr.addr == CDT_ADDR_TD2);
  assign w_tctl = i_csr.we && (i_csr.addr == CDT_ADDR_TCTL);
  assign td_wr_ok = i_debug_mode || !dmode_reg[tsel_reg];
  assign td1_sel = td1_word[tsel_reg];

  assign dcs_val = {CDT_DEBUG_VER, 12'h0, ebm_reg, 2'h0, ebu_reg, 3'h0,
    cause_reg, 3'h0, step_reg, prv_reg};

  assign rdata_next =
    (i_csr.addr == CDT_ADDR_DCS) ? dcs_val :
    (i_csr.addr == CDT_ADDR_RPC) ? rpc_reg :
    (i_csr.addr == CDT_ADDR_DS0) ? ds0_reg :
    (i_csr.addr == CDT_ADDR_DS1) ? ds1_reg :
    (i_csr.addr == CDT_ADDR_TSEL) ? 32'(tsel_reg) :
    (i_csr.addr == CDT_ADDR_TD1) ? td1_sel :
    (i_csr.addr == CDT_ADDR_TD2) ? taddr_reg[tsel_reg] :
    (i_csr.addr == CDT_ADDR_TCTL) ? (32'(mpte_reg) << CDT_TCTL_MPTE_BIT)
      | (32'(mte_reg) << CDT_TCTL_MTE_BIT) : 32'h0;

  // Entry causes and priority
  assign any_dbg = |fire_dbg;
  assign any_exc = |fire_exc && !any_dbg;
  assign ebreak_dbg = i_ebreak && !i_debug_mode
    && ((priv_m && ebm_reg) || (!priv_m && ebu_reg));
  // Exception also ends the step, before handler
  assign step_done = stepping_reg && (i_retire || i_exception);
  assign enter_now = !i_debug_mode && (any_dbg || ebreak_dbg || i_halt_req || step_done);
  assign cause_next = any_dbg ? CDT_CAUSE_TRIG : ebreak_dbg ? CDT_CAUSE_EBREAK :
    i_halt_req ? CDT_CAUSE_HALT : CDT_CAUSE_STEP;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ebm_reg <= 1'b0;
      ebu_reg <= 1'b0;
      step_reg <= 1'b0;
      cause_reg <= 3'h0;
      prv_reg <= CDT_PRV_M;
      rpc_reg <= 32'h0;
      ds0_reg <= 32'h0;
      ds1_reg <= 32'h0;
      stepping_reg <= 1'b0;
    end else begin
      if (w_dcs) begin
        ebm_reg <= i_csr.wdata[CDT_EBM_BIT];
        ebu_reg <= i_csr.wdata[CDT_EBU_BIT];
        step_reg <= i_csr.wdata[CDT_STEP_BIT];
        if (i_csr.wdata[1:0] == CDT_PRV_M || i_csr.wdata[1:0] == CDT_PRV_U) begin
          prv_reg <= i_csr.wdata[1:0];
        end
      end
      if (w_rpc) rpc_reg <= i_csr.wdata;
      if (w_ds0) ds0_reg <= i_csr.wdata;
      if (w_ds1) ds1_reg <= i_csr.wdata;
      // Entry wins over a same-cycle CSR write
      if (enter_now) begin
        cause_reg <= cause_next;
        prv_reg <= priv_m ? CDT_PRV_M : CDT_PRV_U;
        rpc_reg <= i_pipe.pc;
      end
      if (i_dret) stepping_reg <= step_reg;
      else if (enter_now) stepping_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tsel_reg <= '0;
      mte_reg <= 1'b0;
      mpte_reg <= 1'b0;
    end else begin
      if (w_tsel) begin
        tsel_reg <= (i_csr.wdata > 32'(LAST_IDX)) ? LAST_IDX : i_csr.wdata[IW-1:0];
      end
      if (any_exc || i_mtrap) begin
        mpte_reg <= mte_reg;
        mte_reg <= 1'b0;
      end else if (i_mret) begin
        mte_reg <= mpte_reg;
        mpte_reg <= 1'b0;
      end else if (w_tctl) begin
        mte_reg <= i_csr.wdata[CDT_TCTL_MTE_BIT];
        mpte_reg <= i_csr.wdata[CDT_TCTL_MPTE_BIT];
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dmode_reg <= '0;
      act_reg <= '0;
      hit_reg <= '0;
      mm_reg <= '0;
      mu_reg <= '0;
      ex_reg <= '0;
      st_reg <= '0;
      ld_reg <= '0;
      for (int i = 0; i < NUM_TRIG; i++) begin
        match_reg[i] <= 4'h0;
        taddr_reg[i] <= 32'h0;
      end
    end else begin
      for (int i = 0; i < NUM_TRIG; i++) begin
        if (w_td1 && td_wr_ok && tsel_reg == IW'(i)) begin
          if (i_debug_mode) begin
            dmode_reg[i] <= i_csr.wdata[CDT_DMODE_BIT];
            act_reg[i] <= i_csr.wdata[CDT_ACTION_LSB];
          end
          hit_reg[i] <= i_csr.wdata[CDT_HIT_BIT];
          match_reg[i] <= i_csr.wdata[CDT_MATCH_LSB +: 4];
          mm_reg[i] <= i_csr.wdata[CDT_M_BIT];
          mu_reg[i] <= i_csr.wdata[CDT_U_BIT];
          ex_reg[i] <= i_csr.wdata[CDT_EXEC_BIT];
          st_reg[i] <= i_csr.wdata[CDT_STORE_BIT];
          ld_reg[i] <= i_csr.wdata[CDT_LOAD_BIT];
        end
        if (w_td2 && td_wr_ok && tsel_reg == IW'(i)) taddr_reg[i] <= i_csr.wdata;
        // Set beats clear in the same cycle
        if (fire_dbg[i] || (fire_exc[i] && !any_dbg)) hit_reg[i] <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      enter_reg <= 1'b0;
      halted_reg <= 1'b0;
      texc_reg <= 1'b0;
      ebexc_reg <= 1'b0;
      tepc_reg <= 32'h0;
      rdata_reg <= 32'h0;
    end else begin
      enter_reg <= enter_now;
      halted_reg <= enter_now || (i_debug_mode && !i_dret);
      texc_reg <= any_exc;
      ebexc_reg <= i_ebreak && !ebreak_dbg && !i_debug_mode;
      if (any_exc) tepc_reg <= i_pipe.pc;
      rdata_reg <= i_csr.re ? rdata_next : 32'h0;
    end
  end

  assign o_enter_debug = enter_reg;
  assign o_halted = halted_reg;
  assign o_trig_exc = texc_reg;
  assign o_trig_epc = tepc_reg;
  assign o_trig_cause = CDT_EXC_CAUSE_BRK;
  assign o_ebreak_exc = ebexc_reg;
  assign o_resume_pc = rpc_reg;
  assign o_resume_priv = prv_reg;
  assign o_csr_rdata = rdata_reg;

  hit_sticky_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (hit_reg[0] && !(w_td1 && tsel_reg == '0)) |=> hit_reg[0])
    else $error("hit flag dropped without write");
  dbg_prio_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (any_dbg) |=> (o_enter_debug && !o_trig_exc && cause_reg == CDT_CAUSE_TRIG))
    else $error("debug trigger did not win");
  tsel_clip_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (w_tsel && i_csr.wdata > 32'(LAST_IDX)) |=> tsel_reg == LAST_IDX)
    else $error("select not clipped");
  mte_push_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (any_exc) |=> (!mte_reg && mpte_reg && o_trig_exc))
    else $error("enable push wrong");
  mret_pop_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_mret && !any_exc && !i_mtrap) |=> (mte_reg == $past(mpte_reg) && !mpte_reg))
    else $error("enable pop wrong");
  rpc_load_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (enter_now) |=> (rpc_reg == $past(i_pipe.pc)))
    else $error("resume pc not loaded");
  step_halt_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (stepping_reg && i_retire && !i_debug_mode) |=> o_enter_debug)
    else $error("step did not halt");
  ebreak_m_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_ebreak && priv_m && ebm_reg && !i_debug_mode && !any_dbg) |=>
      (o_enter_debug && !o_ebreak_exc && cause_reg == CDT_CAUSE_EBREAK))
    else $error("machine ebreak not to debug");
  ver_fixed_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_csr.re && i_csr.addr == CDT_ADDR_DCS) |=>
      (o_csr_rdata[31:28] == CDT_DEBUG_VER && o_csr_rdata[10:9] == 2'h0))
    else $error("version or stop bits wrong");
endmodule : cdt_debug_csrs

// [core/cdt_pkg.sv]
package cdt_pkg;
  // CSR addresses
  localparam logic [11:0] CDT_ADDR_DCS = 12'h7b0;
  localparam logic [11:0] CDT_ADDR_RPC = 12'h7b1;
  localparam logic [11:0] CDT_ADDR_DS0 = 12'h7b2;
  localparam logic [11:0] CDT_ADDR_DS1 = 12'h7b3;
  localparam logic [11:0] CDT_ADDR_TSEL = 12'h7a0;
  localparam logic [11:0] CDT_ADDR_TD1 = 12'h7a1;
  localparam logic [11:0] CDT_ADDR_TD2 = 12'h7a2;
  localparam logic [11:0] CDT_ADDR_TCTL = 12'h7a5;
  // debug_control_status fields
  localparam logic [3:0] CDT_DEBUG_VER = 4'h4;
  localparam int CDT_VER_LSB = 28;
  localparam int CDT_EBM_BIT = 15;
  localparam int CDT_EBU_BIT = 12;
  localparam int CDT_CAUSE_LSB = 6;
  localparam int CDT_STEP_BIT = 2;
  localparam logic [2:0] CDT_CAUSE_EBREAK = 3'h1;
  localparam logic [2:0] CDT_CAUSE_TRIG = 3'h2;
  localparam logic [2:0] CDT_CAUSE_HALT = 3'h3;
  localparam logic [2:0] CDT_CAUSE_STEP = 3'h4;
  localparam logic [1:0] CDT_PRV_M = 2'h3;
  localparam logic [1:0] CDT_PRV_U = 2'h0;
  // trigger_data_one fields
  localparam logic [3:0] CDT_TRIG_TYPE = 4'h2;
  localparam int CDT_TYPE_LSB = 28;
  localparam int CDT_DMODE_BIT = 27;
  localparam int CDT_HIT_BIT = 20;
  localparam int CDT_ACTION_LSB = 12;
  localparam int CDT_MATCH_LSB = 7;
  localparam int CDT_M_BIT = 6;
  localparam int CDT_U_BIT = 3;
  localparam int CDT_EXEC_BIT = 2;
  localparam int CDT_STORE_BIT = 1;
  localparam int CDT_LOAD_BIT = 0;
  localparam logic [3:0] CDT_MATCH_REGION = 4'h1;
  localparam logic [3:0] CDT_EXC_CAUSE_BRK = 4'h3;
  localparam int CDT_TCTL_MTE_BIT = 3;
  localparam int CDT_TCTL_MPTE_BIT = 7;

  typedef struct packed {
    logic        we;
    logic        re;
    logic [11:0] addr;
    logic [31:0] wdata;
  } cdt_csr_req_s;

  typedef struct packed {
    logic        valid;
    logic [31:0] pc;
    logic [31:0] ls_addr;
    logic        is_load;
    logic        is_store;
  } cdt_pipe_s;
endpackage : cdt_pkg

// [core/cdt_trig_unit.sv]
`timescale 1ns/1ns
module cdt_trig_unit
  import cdt_pkg::*;
(
  // Configuration
  input wire logic [31:0] i_ctrl,
  input wire logic [31:0] i_addr,
  input wire logic i_priv_m,
  // Pipeline
  input wire cdt_pipe_s i_pipe,
  // Match
  output logic o_match
);
  logic [31:0] mask;
  logic region;
  logic exec_hit;
  logic ls_hit;
  logic priv_ok;

  // Trailing ones mark the don't-care low bits plus one more
  function automatic logic [31:0] region_mask(input logic [31:0] a);
    logic [31:0] m;
    m = ~(a ^ (a + 32'h1));
    return m;
  endfunction : region_mask

  assign region = (i_ctrl[CDT_MATCH_LSB +: 4] == CDT_MATCH_REGION);
  assign mask = region ? region_mask(i_addr) : 32'hffffffff;
  assign priv_ok = i_priv_m ? i_ctrl[CDT_M_BIT] : i_ctrl[CDT_U_BIT];
  assign exec_hit = i_ctrl[CDT_EXEC_BIT] && ((i_pipe.pc & mask) == (i_addr & mask));
  assign ls_hit = ((i_ctrl[CDT_LOAD_BIT] && i_pipe.is_load)
    || (i_ctrl[CDT_STORE_BIT] && i_pipe.is_store))
    && ((i_pipe.ls_addr & mask) == (i_addr & mask));
  assign o_match = i_pipe.valid && priv_ok && (exec_hit || ls_hit);
endmodule : cdt_trig_unit

// [sim/cdt_dbg_host.sv]
`timescale 1ns/1ns
module cdt_dbg_host
  import cdt_pkg::*;
(
  // Clock
  input wire logic i_sys_clk,
  // CSR path towards the core
  input wire logic [31:0] i_rdata,
  output cdt_csr_req_s o_req
);
  initial begin
    o_req = '0;
  end

  // Debugger-side access: rewrites resume PC, privilege and action bits
  // Strobe held one full cycle, read data taken at the following edge
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge i_sys_clk);
    #1;
    o_req = '{we: w, re: !w, addr: a, wdata: d};
    @(posedge i_sys_clk);
    #1;
    o_req = '0;
    q = i_rdata;
  endtask : acc
endmodule : cdt_dbg_host

// [sim/core_debug_csrs_and_triggers_tb_top.sv]
`timescale 1ns/1ns
module core_debug_csrs_and_triggers_tb_top;
  import cdt_pkg::*;
  localparam int NT = 2;
  logic i_sys_clk = 1'b0;
  logic i_rst_n = 1'b0;
  cdt_csr_req_s csr;
  cdt_pipe_s pipe = '0;
  logic [1:0] priv = 2'h3;
  logic dbg_mode = 1'b1;
  // Order: ebreak, halt, retire, exception, dret, mret, mtrap
  logic [6:0] ev_r = '0;
  logic [31:0] rdata, epc, rpc, d, q, pc, base;
  logic ent, halted, texc, bexc;
  logic [3:0] tcause;
  logic [1:0] rprv;
  logic [11:0] sa [3] = '{CDT_ADDR_DS0, CDT_ADDR_DS1, CDT_ADDR_RPC};
  int errors = 0;
  int checks = 0;

  always #2 i_sys_clk = ~i_sys_clk;

  cdt_dbg_host cdt_dbg_host_inst (.i_sys_clk(i_sys_clk), .i_rdata(rdata), .o_req(csr));

  cdt_debug_csrs #(.NUM_TRIG(NT)) cdt_debug_csrs_inst (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_csr(csr), .o_csr_rdata(rdata),
    .i_pipe(pipe), .i_priv(priv), .i_debug_mode(dbg_mode), .i_ebreak(ev_r[6]),
    .i_halt_req(ev_r[5]), .i_retire(ev_r[4]), .i_exception(ev_r[3]), .i_dret(ev_r[2]),
    .i_mret(ev_r[1]), .i_mtrap(ev_r[0]), .o_enter_debug(ent), .o_halted(halted),
    .o_trig_exc(texc), .o_trig_epc(epc), .o_trig_cause(tcause), .o_ebreak_exc(bexc),
    .o_resume_pc(rpc), .o_resume_priv(rprv));

  task automatic end_of_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    cdt_dbg_host_inst.acc(1'b1, a, v, q);
  endtask : wr

  task automatic get(input logic [11:0] a);
    cdt_dbg_host_inst.acc(1'b0, a, 32'h0, q);
  endtask : get

  function automatic logic [31:0] clip(input logic [31:0] v);
    clip = (v > NT - 1) ? NT - 1 : v;
  endfunction : clip

  function automatic cdt_pipe_s px(input logic [31:0] p, input logic [31:0] la, input logic ld);
    px = '{valid: 1'b1, pc: p, ls_addr: la, is_load: ld, is_store: 1'b0};
  endfunction : px

  // One cycle of core activity outside debug mode; reaction sampled one edge later
  task automatic fire(input logic [6:0] ev, input cdt_pipe_s p);
    @(posedge i_sys_clk);
    #1;
    dbg_mode = 1'b0;
    ev_r = ev;
    pipe = p;
    @(posedge i_sys_clk);
    #1;
    ev_r = '0;
    pipe = '0;
    dbg_mode = 1'b1;
  endtask : fire

  task automatic entry(input logic e, input logic [2:0] c);
    chk(ent, e, "debug entry");
    get(CDT_ADDR_DCS);
    if (e) begin
      chk(q[8:6], c, "cause");
    end
  endtask : entry

  initial begin
    void'($urandom(66));
    repeat (8) @(posedge i_sys_clk);
    #1;
    i_rst_n = 1'b1;
    chk(rprv, CDT_PRV_M, "reset prv");
    get(CDT_ADDR_DCS);
    chk(q, 32'h4000_0003, "status reset");
    wr(CDT_ADDR_DCS, 32'hffff_ffff);
    get(CDT_ADDR_DCS);
    chk(q, 32'h4000_9007, "status fixed bits");
    wr(CDT_ADDR_DCS, 32'h0000_8003);
    foreach (sa[i]) begin
      d = $urandom();
      wr(sa[i], d);
      get(sa[i]);
      chk(q, d, "storage");
    end
    chk(rpc, d, "resume pc");
    for (int i = 0; i < 7; i++) begin
      d = (i == 0) ? 32'h9 : $urandom_range(15);
      wr(CDT_ADDR_TSEL, d);
      get(CDT_ADDR_TSEL);
      chk(q, clip(d), "select");
    end
    pc = $urandom() & 32'hffff_fffc;
    base = $urandom() & 32'hffff_fff0;
    wr(CDT_ADDR_TSEL, 32'h0);
    wr(CDT_ADDR_TD1, 32'hf000_1044);
    wr(CDT_ADDR_TD2, pc);
    wr(CDT_ADDR_TSEL, 32'h1);
    wr(CDT_ADDR_TD1, 32'h0000_00c1);
    wr(CDT_ADDR_TD2, base | 32'h3);
    dbg_mode = 1'b0;
    wr(CDT_ADDR_TD1, 32'h0000_10c1);
    dbg_mode = 1'b1;
    get(CDT_ADDR_TD1);
    chk(q, 32'h2000_00c1, "action kept");
    wr(CDT_ADDR_TSEL, 32'h0);
    get(CDT_ADDR_TD1);
    chk(q, 32'h2000_1044, "unit 0 control");
    get(CDT_ADDR_TD2);
    chk(q, pc, "unit 0 address");
    wr(CDT_ADDR_TCTL, 32'h8);
    fire(7'h0, px(pc, 32'h0, 1'b0));
    chk(halted, 1'b1, "halted");
    chk(rpc, pc, "resume pc from decode");
    entry(1'b1, CDT_CAUSE_TRIG);
    get(CDT_ADDR_TD1);
    chk(q, 32'h2010_1044, "hit");
    wr(CDT_ADDR_TD1, 32'h0000_1044);
    get(CDT_ADDR_TD1);
    chk(q, 32'h2000_1044, "hit cleared");
    fire(7'h04, '0);
    fire(7'h0, px(pc + 32'h40, base + 32'h5, 1'b1));
    chk(texc, 1'b1, "load in region");
    chk(epc, pc + 32'h40, "epc");
    chk(tcause, CDT_EXC_CAUSE_BRK, "trap cause");
    get(CDT_ADDR_TCTL);
    chk(q, 32'h80, "enable pushed");
    fire(7'h0, px(pc + 32'h40, base + 32'h7, 1'b1));
    chk(texc, 1'b0, "masked in handler");
    fire(7'h02, '0);
    get(CDT_ADDR_TCTL);
    chk(q, 32'h8, "enable popped");
    fire(7'h0, px(pc + 32'h40, base + 32'h8, 1'b1));
    chk(texc, 1'b0, "outside region");
    fire(7'h0, px(pc, base + 32'h2, 1'b1));
    chk(texc, 1'b0, "debug wins");
    entry(1'b1, CDT_CAUSE_TRIG);
    fire(7'h40, '0);
    entry(1'b1, CDT_CAUSE_EBREAK);
    priv = CDT_PRV_U;
    fire(7'h40, '0);
    chk(bexc, 1'b1, "user ebreak traps");
    entry(1'b0, 3'h0);
    wr(CDT_ADDR_DCS, 32'h0000_9003);
    fire(7'h40, '0);
    entry(1'b1, CDT_CAUSE_EBREAK);
    chk(rprv, CDT_PRV_U, "prv saved");
    priv = CDT_PRV_M;
    fire(7'h60, '0);
    entry(1'b1, CDT_CAUSE_EBREAK);
    fire(7'h20, '0);
    entry(1'b1, CDT_CAUSE_HALT);
    wr(CDT_ADDR_DCS, 32'h0000_8002);
    chk(rprv, CDT_PRV_M, "bad prv ignored");
    wr(CDT_ADDR_DCS, 32'h0000_8004);
    chk(rprv, CDT_PRV_U, "prv rewritten");
    fire(7'h04, '0);
    fire(7'h0, '0);
    chk(ent, 1'b0, "no halt before retire");
    fire(7'h10, '0);
    entry(1'b1, CDT_CAUSE_STEP);
    fire(7'h04, '0);
    fire(7'h08, '0);
    entry(1'b1, CDT_CAUSE_STEP);
    fire(7'h01, '0);
    get(CDT_ADDR_TCTL);
    chk(q, 32'h80, "trap pushes enable");
    // A unit claimed by the debugger refuses writes from outside debug mode
    wr(CDT_ADDR_TSEL, 32'h1);
    wr(CDT_ADDR_TD1, 32'h0800_00c1);
    dbg_mode = 1'b0;
    wr(CDT_ADDR_TD2, 32'h0);
    dbg_mode = 1'b1;
    get(CDT_ADDR_TD2);
    chk(q, base | 32'h3, "locked unit kept");
    end_of_test();
  end

  // Whole run is under two hundred cycles; this leaves a wide margin
  initial begin
    #100000;
    errors++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    end_of_test();
  end
endmodule : core_debug_csrs_and_triggers_tb_top
